/* File: core/dcat_pkg.sv */
// constants and types shared by the dma channel addressing block
// assumes a single 200 MHz clock and an asynchronous active high reset

package dcat_pkg;

    // ----------------------------------------------------------------
    // register selection and layout
    // ----------------------------------------------------------------
    localparam int REG_W = 16;                  // register width
    localparam logic REG_GTCR = 1'h0;           // global timeout control
    localparam logic REG_CCR  = 1'h1;           // channel control
    localparam logic [15:0] GTCR_RESET = 16'h0000;
    localparam logic [15:0] CCR_RESET  = 16'h0000;
    localparam logic [15:0] GT_RW_MASK = 16'h0003; // upper bits read 0
    localparam int GT_SINGLE = 0;               // single port enable
    localparam int GT_DUAL   = 1;               // dual port enable
    localparam int CC_DST_LO = 14;              // destination mode 15:14
    localparam int CC_SRC_LO = 12;              // source mode 13:12
    localparam int CC_END_OF_PROGRAMMING = 11;
    localparam int CC_RSVD   = 10;              // software keeps it 0
    localparam int CC_REPEAT = 9;
    localparam int CC_AUTO_INITIALIZATION = 8;
    localparam int CC_EN     = 7;
    localparam int CC_CHANNEL_PRIORITY   = 6;
    localparam int CC_FS     = 5;
    localparam int CC_SYNC_LO = 0;              // sync event 4:0
    localparam int SYNC_W    = 5;
    localparam logic [4:0] SYNC_NONE = 5'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;        // 200 MHz
    localparam int TIMEOUT_NS    = 1280;        // request wait limit
    localparam int TIMEOUT_CYC   =
        (TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        AM_CONST  = 2'h0,                       // fixed address
        AM_POST   = 2'h1,                       // post increment
        AM_SINGLE = 2'h2,                       // element index
        AM_DOUBLE = 2'h3                        // element / frame index
    } dcat_amode_t;

    typedef enum logic [1:0] {
        DT_8 = 2'h0, DT_16 = 2'h1, DT_32 = 2'h2
    } dcat_dtype_t;

    typedef enum logic [1:0] {
        PK_OTHER = 2'h0, PK_SINGLE = 2'h1, PK_DUAL = 2'h2
    } dcat_port_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0, ST_WAIT = 2'h1, ST_READ = 2'h3, ST_WRITE = 2'h2
    } dcat_state_t;

    // bytes in one element; a bad code falls back to one byte
    function automatic logic [2:0] elem_bytes(input dcat_dtype_t dt);
        case (dt)
            DT_16:   elem_bytes = 3'h2;
            DT_32:   elem_bytes = 3'h4;
            default: elem_bytes = 3'h1;
        endcase
    endfunction : elem_bytes

endpackage : dcat_pkg

/* File: core/dcat_agen_if.sv */
// link between the channel sequencer and one address generator
// assumes dcat_pkg is compiled first

`timescale 1ns/1ps

interface dcat_agen_if
    import dcat_pkg::*;
#(
    parameter int AW = 24
);
    logic             load;          // take start address
    logic [AW-1:0]    start;         // programmed start address
    logic             step;          // one element finished
    logic             last_in_frame; // that element closed its frame
    dcat_amode_t      mode;          // address update mode
    dcat_dtype_t      dtype;         // element size
    logic [15:0]      elem_idx;      // signed element index
    logic [15:0]      frame_idx;     // signed frame index
    logic [AW-1:0]    addr;          // current element address
    logic [AW-1:0]    last_byte;     // last byte touched

    modport ctrl (output load, start, step, last_in_frame, mode, dtype,
                  elem_idx, frame_idx, input addr, last_byte);
    modport gen  (input load, start, step, last_in_frame, mode, dtype,
                  elem_idx, frame_idx, output addr, last_byte);
endinterface : dcat_agen_if

/* File: core/dcat_addr_gen.sv */
// one address generator: source or destination side of a channel
// assumes the sequencer pulses step once per finished element

`timescale 1ns/1ps

module dcat_addr_gen
    import dcat_pkg::*;
#(
    parameter int AW = 24
) (
    input  wire logic   ref_clk,
    input  wire logic   rst,
    dcat_agen_if.gen    agen
);
    // ----------------------------------------------------------------
    // next address
    // ----------------------------------------------------------------
    logic [AW-1:0] addr;          // element address
    logic [AW-1:0] last_byte;     // last byte of last element
    logic [AW-1:0] next_addr;
    logic [AW-1:0] next_last;
    logic [AW-1:0] size;          // element size in bytes

    // load wins over step so an auto-init reload starts clean, but the
    // last byte of the finished element is kept even then
    always_comb begin
        next_addr = addr;
        next_last = last_byte;
        size = AW'(elem_bytes(agen.dtype));
        if (agen.step) begin
            // address of the final byte, before any update
            next_last = addr + size - AW'(1);
        end
        if (agen.load) begin
            next_addr = agen.start;
        end else if (agen.step) begin
            unique case (agen.mode)
                AM_CONST:  next_addr = addr;
                AM_POST:   next_addr = addr + size;
                AM_SINGLE: next_addr = addr
                    + AW'($signed(agen.elem_idx));
                AM_DOUBLE: begin
                    if (agen.last_in_frame) begin
                        next_addr = addr + AW'($signed(agen.frame_idx));
                    end else begin
                        next_addr = addr + AW'($signed(agen.elem_idx));
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            addr      <= '0;
            last_byte <= '0;
        end else begin
            addr      <= next_addr;
            last_byte <= next_last;
        end
    end

    assign agen.addr      = addr;
    assign agen.last_byte = last_byte;

endmodule : dcat_addr_gen

/* File: core/dcat_channel.sv */
// dma channel: control register, global timeout control, sequencer
// assumes one memory port with req/gnt handshake on ref_clk and that
// sync event pulses come from logic on the same clock
//
// Overview of operation
// - bit 1 enables dual port timeout counter
// - bit 0 enables single port timeout counter
// - disabled counter never raises a timeout error
// - global register bits 15..2 read zero
// - sixteen bit channel control register field layout
// - destination mode 00b keeps address constant
// - mode 01b steps by 1, 2 or 4
// - mode 10b adds element index each element
// - mode 11b adds element or frame index
// - end address is last byte touched
// - enable bit starts and stops the channel
// - priority bit sets low or high level
// - frame sync bit: element or frame per event
// - sync field picks event, zero means none
// - auto-init together with repeat or end-programming reruns the transfer
// - source mode uses same four encodings

`timescale 1ns/1ps

module dcat_channel
    import dcat_pkg::*;
#(
    parameter int AW          = 24,          // byte address width
    parameter int CW          = 16,          // element / frame count width
    parameter int TIMEOUT_LIM = TIMEOUT_CYC  // request wait limit
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // register port
    input  wire logic               io_wr,
    input  wire logic               io_rd,
    input  wire logic               io_sel,
    input  wire logic [REG_W-1:0]   io_wdata,
    output var  logic [REG_W-1:0]   io_rdata,
    // transfer setup
    input  wire dcat_dtype_t        data_type,
    input  wire logic [AW-1:0]      src_start,
    input  wire logic [AW-1:0]      dst_start,
    input  wire logic [15:0]        src_elem_index,
    input  wire logic [15:0]        dst_elem_index,
    input  wire logic [15:0]        src_frame_index,
    input  wire logic [15:0]        dst_frame_index,
    input  wire logic [CW-1:0]      elem_count,
    input  wire logic [CW-1:0]      frame_count,
    input  wire dcat_port_t         src_port,
    input  wire dcat_port_t         dst_port,
    input  wire logic [31:0]        sync_events,
    // memory port
    output var  logic               mem_req,
    output var  logic               mem_we,
    output var  logic [AW-1:0]      mem_addr,
    output var  logic [31:0]        mem_wdata,
    output var  dcat_port_t         mem_port,
    output var  logic               mem_high_channel_priority,
    input  wire logic               mem_gnt,
    input  wire logic [31:0]        mem_rdata,
    // status
    output var  logic               xfer_done,
    output var  logic               timeout_error,
    output var  logic               channel_busy,
    output var  logic [AW-1:0]      src_last_byte,
    output var  logic [AW-1:0]      dst_last_byte
);
    // ----------------------------------------------------------------
    // address generators
    // ----------------------------------------------------------------
    dcat_agen_if #(.AW(AW)) src_if ();      // read side
    dcat_agen_if #(.AW(AW)) dst_if ();      // write side

    dcat_addr_gen #(.AW(AW)) u_src_gen (
        .ref_clk (ref_clk),
        .rst     (rst),
        .agen    (src_if.gen)
    );

    dcat_addr_gen #(.AW(AW)) u_dst_gen (
        .ref_clk (ref_clk),
        .rst     (rst),
        .agen    (dst_if.gen)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dcat_state_t       state;         // sequencer state
    logic [REG_W-1:0]  gtcr;          // global timeout control
    logic [REG_W-1:0]  ccr;           // channel control
    logic [CW-1:0]     elem_left;     // elements left in frame
    logic [CW-1:0]     frame_left;    // frames left in block
    logic              sync_pend;     // sync event seen, not used
    logic [15:0]       wait_cnt;      // cycles a request waited
    logic [31:0]       data_buf;      // element in flight

    dcat_state_t       next_state;
    logic [REG_W-1:0]  next_gtcr;
    logic [REG_W-1:0]  next_ccr;
    logic [CW-1:0]     next_elem_left;
    logic [CW-1:0]     next_frame_left;
    logic              next_sync_pend;
    logic [15:0]       next_wait_cnt;
    logic [31:0]       next_data_buf;
    logic [REG_W-1:0]  next_io_rdata;
    logic              next_mem_req;
    logic              next_mem_we;
    logic [AW-1:0]     next_mem_addr;
    logic [31:0]       next_mem_wdata;
    dcat_port_t        next_mem_port;
    logic              next_done;
    logic              next_tmo;

    // ----------------------------------------------------------------
    // decoded fields and helpers
    // ----------------------------------------------------------------
    logic [SYNC_W-1:0] sync_sel;      // selected event number
    logic              sync_evt;      // selected event this cycle
    logic              no_sync;       // channel free running
    logic              granted;       // request taken this cycle
    logic              tmo_hit;       // wait limit reached
    logic              rerun;         // block restarts after done

    // timeout counter enable for the port being requested
    function automatic logic port_tmo_en(input dcat_port_t p,
                                         input logic [REG_W-1:0] g);
        case (p)
            PK_DUAL:   port_tmo_en = g[GT_DUAL];
            PK_SINGLE: port_tmo_en = g[GT_SINGLE];
            default:   port_tmo_en = 1'b0;
        endcase
    endfunction : port_tmo_en

    always_comb begin
        sync_sel = ccr[CC_SYNC_LO +: SYNC_W];
        no_sync  = (sync_sel == SYNC_NONE);
        sync_evt = !no_sync && sync_events[sync_sel];
        granted  = mem_req && mem_gnt;
        // tmo_hit is masked when the requested port's counter is disabled
        tmo_hit  = mem_req && !mem_gnt
                   && port_tmo_en(mem_port, gtcr)
                   && (wait_cnt == 16'(TIMEOUT_LIM - 1));
        rerun    = ccr[CC_AUTO_INITIALIZATION]
                   && (ccr[CC_REPEAT] || ccr[CC_END_OF_PROGRAMMING]);
    end

    // ----------------------------------------------------------------
    // generator controls
    // ----------------------------------------------------------------
    // both sides share data type; modes come from the control register
    always_comb begin
        src_if.start         = src_start;
        src_if.mode          = dcat_amode_t'(ccr[CC_SRC_LO +: 2]);
        src_if.dtype         = data_type;
        src_if.elem_idx      = src_elem_index;
        src_if.frame_idx     = src_frame_index;
        src_if.last_in_frame = (elem_left == CW'(1));
        dst_if.start         = dst_start;
        dst_if.mode          = dcat_amode_t'(ccr[CC_DST_LO +: 2]);
        dst_if.dtype         = data_type;
        dst_if.elem_idx      = dst_elem_index;
        dst_if.frame_idx     = dst_frame_index;
        dst_if.last_in_frame = (elem_left == CW'(1));
    end

    // ----------------------------------------------------------------
    // sequencer, register port and timeout: next values
    // ----------------------------------------------------------------
    always_comb begin
        next_state      = state;
        next_gtcr       = gtcr;
        next_ccr        = ccr;
        next_elem_left  = elem_left;
        next_frame_left = frame_left;
        next_sync_pend  = sync_pend;
        next_data_buf   = data_buf;
        next_io_rdata   = io_rdata;
        next_mem_req    = mem_req;
        next_mem_we     = mem_we;
        next_mem_addr   = mem_addr;
        next_mem_wdata  = mem_wdata;
        next_mem_port   = mem_port;
        next_done       = 1'b0;
        next_tmo        = timeout_error;
        src_if.load     = 1'b0;
        src_if.step     = 1'b0;
        dst_if.load     = 1'b0;
        dst_if.step     = 1'b0;

        // wait counter runs only while a request is refused
        if (mem_req && !mem_gnt && wait_cnt != 16'hFFFF) begin
            next_wait_cnt = wait_cnt + 16'h0001;
        end else if (mem_req && !mem_gnt) begin
            next_wait_cnt = wait_cnt;
        end else begin
            next_wait_cnt = 16'h0000;
        end

        unique case (state)
            // idle: a set enable bit starts the block
            ST_IDLE: begin
                if (ccr[CC_EN]) begin
                    src_if.load     = 1'b1;
                    dst_if.load     = 1'b1;
                    next_elem_left  = elem_count;
                    next_frame_left = frame_count;
                    next_sync_pend  = 1'b0;
                    next_state      = ST_WAIT;
                end
            end
            // wait for the selected event, or go at once without one
            ST_WAIT: begin
                if (!ccr[CC_EN]) begin
                    next_state = ST_IDLE;
                end else if (no_sync || sync_pend) begin
                    next_sync_pend = 1'b0;
                    next_state     = ST_READ;
                end
            end
            // read one element from the source
            ST_READ: begin
                if (!mem_req) begin
                    next_mem_req  = 1'b1;
                    next_mem_we   = 1'b0;
                    next_mem_addr = src_if.addr;
                    next_mem_port = src_port;
                end else if (granted) begin
                    next_mem_req  = 1'b0;
                    next_data_buf = mem_rdata;
                    next_state    = ST_WRITE;
                end
            end
            // write it to the destination and update the counts
            ST_WRITE: begin
                if (!mem_req) begin
                    next_mem_req   = 1'b1;
                    next_mem_we    = 1'b1;
                    next_mem_addr  = dst_if.addr;
                    next_mem_wdata = data_buf;
                    next_mem_port  = dst_port;
                end else if (granted) begin
                    next_mem_req = 1'b0;
                    next_mem_we  = 1'b0;
                    src_if.step  = 1'b1;
                    dst_if.step  = 1'b1;
                    if (elem_left != CW'(1)) begin
                        next_elem_left = elem_left - CW'(1);
                        // frame sync keeps going inside the frame
                        if (ccr[CC_FS] && !no_sync) begin
                            next_state = ST_READ;
                        end else begin
                            next_state = ST_WAIT;
                        end
                    end else if (frame_left != CW'(1)) begin
                        next_elem_left  = elem_count;
                        next_frame_left = frame_left - CW'(1);
                        next_state      = ST_WAIT;
                    end else begin
                        next_done = 1'b1;
                        if (rerun) begin
                            // end-programming is used up by one rerun
                            next_ccr[CC_END_OF_PROGRAMMING] = 1'b0;
                            src_if.load     = 1'b1;
                            dst_if.load     = 1'b1;
                            next_elem_left  = elem_count;
                            next_frame_left = frame_count;
                            next_state      = ST_WAIT;
                        end else begin
                            next_ccr[CC_EN] = 1'b0;
                            next_state      = ST_IDLE;
                        end
                    end
                end
            end
        endcase

        // a request stuck too long ends the block and stops the channel
        if (tmo_hit) begin
            next_ccr[CC_EN] = 1'b0;
            next_mem_req    = 1'b0;
            next_mem_we     = 1'b0;
            next_state      = ST_IDLE;
        end

        // software writes come after hardware updates so they win
        if (io_wr && io_sel == REG_GTCR) begin
            next_gtcr = io_wdata & GT_RW_MASK;
        end
        if (io_wr && io_sel == REG_CCR) begin
            next_ccr = io_wdata;
            next_tmo = 1'b0;
        end

        // events that land on a clear are kept
        if (tmo_hit) begin
            next_tmo = 1'b1;
        end
        if (sync_evt && state != ST_IDLE) begin
            next_sync_pend = 1'b1;
        end

        // read data is registered, ready one cycle after io_rd
        if (io_rd) begin
            next_io_rdata = (io_sel == REG_CCR) ? ccr
                                                : (gtcr & GT_RW_MASK);
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state         <= ST_IDLE;
            gtcr          <= GTCR_RESET;
            ccr           <= CCR_RESET;
            elem_left     <= '0;
            frame_left    <= '0;
            sync_pend     <= 1'b0;
            wait_cnt      <= 16'h0000;
            data_buf      <= 32'h0000_0000;
            io_rdata      <= 16'h0000;
            mem_req       <= 1'b0;
            mem_we        <= 1'b0;
            mem_addr      <= '0;
            mem_wdata     <= 32'h0000_0000;
            mem_port      <= PK_OTHER;
            mem_high_channel_priority <= 1'b0;
            xfer_done     <= 1'b0;
            timeout_error <= 1'b0;
            channel_busy  <= 1'b0;
            src_last_byte <= '0;
            dst_last_byte <= '0;
        end else begin
            state         <= next_state;
            gtcr          <= next_gtcr;
            ccr           <= next_ccr;
            elem_left     <= next_elem_left;
            frame_left    <= next_frame_left;
            sync_pend     <= next_sync_pend;
            wait_cnt      <= next_wait_cnt;
            data_buf      <= next_data_buf;
            io_rdata      <= next_io_rdata;
            mem_req       <= next_mem_req;
            mem_we        <= next_mem_we;
            mem_addr      <= next_mem_addr;
            mem_wdata     <= next_mem_wdata;
            mem_port      <= next_mem_port;
            mem_high_channel_priority <= next_ccr[CC_CHANNEL_PRIORITY];
            xfer_done     <= next_done;
            timeout_error <= next_tmo;
            channel_busy  <= (next_state != ST_IDLE);
            src_last_byte <= src_if.last_byte;
            dst_last_byte <= dst_if.last_byte;
        end
    end

endmodule : dcat_channel

/* File: sim/dcat_mem_model.sv */
// partner: memory port that grants at random or stalls on demand
`timescale 1ns/1ps
module dcat_mem_model (
    input  wire logic        ref_clk, rst, mem_req, stall,
    output var  logic        mem_gnt,
    output var  logic [31:0] mem_rdata
);
    // random grant; rdata toggles so stale data never looks valid
    always_ff @(posedge ref_clk or posedge rst)
        if (rst) begin
            mem_gnt   <= 1'b0;
            mem_rdata <= 32'h0;
        end else begin
            mem_gnt   <= mem_req && !stall && !mem_gnt && $urandom % 2 == 1;
            mem_rdata <= ~mem_rdata;
        end
endmodule : dcat_mem_model

/* File: sim/dcat_channel_checker.sv */
// checker: port timing of the channel, bound onto dcat_channel
`timescale 1ns/1ps
module dcat_channel_checker
    import dcat_pkg::*;
#(parameter int TIMEOUT_LIM = 8) (
    input wire logic             ref_clk, rst, io_wr, io_rd, io_sel,
    input wire logic [REG_W-1:0] io_wdata, io_rdata,
    input wire logic             mem_req, mem_gnt, mem_high_channel_priority,
    input wire logic             xfer_done, timeout_error, channel_busy,
    input wire dcat_port_t       mem_port
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_gt; io_rd && !io_sel |=> io_rdata[15:2] == 14'h0; endproperty
    a_gt: assert property (p_gt) else $error("gt upper bits");
    property p_hold; !io_rd |=> $stable(io_rdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_req; mem_req && !mem_gnt |=> mem_req || timeout_error;
    endproperty
    a_req: assert property (p_req) else $error("req dropped");
    property p_port; $rose(timeout_error) |-> $past(mem_port) != PK_OTHER;
    endproperty
    a_port: assert property (p_port) else $error("bad timeout");
    property p_wait; $rose(timeout_error) |-> $past(mem_req, TIMEOUT_LIM);
    endproperty
    a_wait: assert property (p_wait) else $error("early timeout");
    property p_channel_priority; (io_wr && io_sel ##1 !io_wr)
        |=> mem_high_channel_priority == $past(io_wdata[6], 2); endproperty
    a_channel_priority: assert property (p_channel_priority) else $error("channel_priority");
    property p_run; io_wr && io_sel && io_wdata[7] && !channel_busy
        |-> ##2 channel_busy; endproperty
    a_run: assert property (p_run) else $error("no start");
    property p_done; xfer_done |=> !xfer_done; endproperty
    a_done: assert property (p_done) else $error("done width");
endmodule : dcat_channel_checker
bind dcat_channel dcat_channel_checker #(.TIMEOUT_LIM(TIMEOUT_LIM)) u_chk (
    .ref_clk, .rst, .io_wr, .io_rd, .io_sel, .io_wdata, .io_rdata, .mem_req,
    .mem_gnt, .mem_high_channel_priority, .xfer_done, .timeout_error, .channel_busy,
    .mem_port);

/* File: sim/tb.sv */
// tb: random address-mode runs, register and timeout checks
// assumes TIMEOUT_LIM 8 and the random-grant memory model
`timescale 1ns/1ps
module tb import dcat_pkg::*; ;
    logic ref_clk = 0, rst = 1, io_wr = 0, io_rd = 0, io_sel = 0, stall = 0;
    logic [15:0] io_wdata = 0, io_rdata, sei = 0, dei = 0, sfi = 0, dfi = 0;
    logic [23:0] ss = 0, ds = 0, ma, dl, ld, sl, ls, qs[$], qd[$];
    logic [31:0] mem_rdata;
    logic        mem_req, mem_we, mem_gnt, hp, done, terr;
    dcat_dtype_t dt = DT_8;
    dcat_port_t  dp = PK_OTHER;
    int          fails = 0, n_checks = 0;
    always #2.5 ref_clk = ~ref_clk;
    dcat_channel #(.TIMEOUT_LIM(8)) dut (.ref_clk, .rst, .io_wr, .io_rd,
        .io_sel, .io_wdata, .io_rdata, .data_type(dt), .src_start(ss),
        .dst_start(ds), .src_elem_index(sei), .dst_elem_index(dei),
        .src_frame_index(sfi), .dst_frame_index(dfi), .elem_count(16'h2),
        .frame_count(16'h2), .src_port(dp), .dst_port(dp),
        .sync_events(32'h0), .mem_req, .mem_we, .mem_addr(ma), .mem_wdata(),
        .mem_port(), .mem_high_channel_priority(hp), .mem_gnt, .mem_rdata,
        .xfer_done(done), .timeout_error(terr), .channel_busy(),
        .src_last_byte(sl), .dst_last_byte(dl));
    dcat_mem_model mem (.ref_clk, .rst, .mem_req, .stall, .mem_gnt,
        .mem_rdata);
    task chk(input logic [31:0] s, e, input string nm);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task end_of_test;
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    function automatic logic [23:0] sz;
        return dt == DT_32 ? 24'h4 : dt == DT_16 ? 24'h2 : 24'h1;
    endfunction : sz
    function automatic logic [23:0] nx(logic [1:0] m, logic [23:0] a,
                                       logic l, logic [15:0] ei, fi);
        if (m == 2'h1) return a + sz();
        if (m == 2'h2 || (m == 2'h3 && !l)) return a + {{8{ei[15]}}, ei};
        if (m == 2'h3) return a + {{8{fi[15]}}, fi};
        return a;
    endfunction : nx
    task wr(input logic s, input logic [15:0] d);
        @(posedge ref_clk) {io_wr, io_sel, io_wdata} <= {1'b1, s, d};
        @(posedge ref_clk) io_wr <= 1'b0;
    endtask : wr
    task rd(input logic s, input logic [15:0] e);
        @(posedge ref_clk) {io_rd, io_sel} <= {1'b1, s};
        @(posedge ref_clk) io_rd <= 1'b0;
        #1 chk(io_rdata, e, "rdata");
    endtask : rd
    // model: two frames of two elements, queue every address
    task go(input logic [1:0] m, sm, input logic p);
        logic [23:0] a, b;
        wr(1'b1, {m, sm, 4'h0, 1'b1, p, 6'h00});
        a = ss;
        b = ds;
        for (int i = 0; i < 4; i++) begin
            qs.push_back(a);
            qd.push_back(b);
            ld = b;
            ls = a;
            a = nx(sm, a, i[0], sei, sfi);
            b = nx(m, b, i[0], dei, dfi);
        end
    endtask : go
    task wd;
        int k;
        for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge ref_clk);
        if (k == 300) begin
            fails++;
            end_of_test();
        end
    endtask : wd
    always @(posedge ref_clk) if (mem_req && mem_gnt)
        chk(ma, mem_we ? qd.pop_front() : qs.pop_front(), "adr");
    initial begin
        void'($urandom(32'h448c885b));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(1'b0, 16'h0000);
        wr(1'b1, 16'hFB7F);
        rd(1'b1, 16'hFB7F);
        wr(1'b0, 16'hFFFF);
        rd(1'b0, 16'h0003);
        for (int m = 0; m < 12; m++) begin
            @(posedge ref_clk);
            dt <= dcat_dtype_t'(m % 3);
            {ss, ds} <= 48'({$urandom, $urandom});
            {sei, dei, sfi, dfi} <= {$urandom, $urandom};
            go(2'(m / 3), 2'($urandom), m[0]);
            wd();
            @(negedge ref_clk); // last bytes land a cycle after done
            chk(dl, ld + sz() - 24'h1, "last");
            chk(sl, ls + sz() - 24'h1, "slast");
            chk(hp, m[0], "channel_priority");
            chk(qd.size(), 0, "count");
        end
        @(posedge ref_clk) stall <= 1'b1;
        dp <= PK_SINGLE;
        go(2'h0, 2'h0, 1'b0);
        repeat (40) @(posedge ref_clk);
        chk(terr, 1, "timeout");
        rd(1'b1, 16'h0000);
        qs.delete();
        qd.delete();
        dp <= PK_DUAL; // dual counter off, single counter left on
        wr(1'b0, 16'h0001);
        go(2'h0, 2'h0, 1'b0);
        repeat (40) @(posedge ref_clk);
        chk(terr, 0, "no timeout");
        @(posedge ref_clk) stall <= 1'b0;
        wd();
        end_of_test();
    end
endmodule : tb
